// ### pcd_defines.svh
`ifndef PCD_DEFINES_SVH
`define PCD_DEFINES_SVH

// register byte offsets
`define PCD_OFS_CONFIG      8'h70
`define PCD_OFS_DUTY        8'h74
`define PCD_OFS_STATUS      8'h78

// configuration field positions
`define PCD_CFG_ENABLE_BIT  0
`define PCD_CFG_SRC_LO      1
`define PCD_CFG_SRC_HI      2
`define PCD_CFG_FORCE_BIT   3
`define PCD_CFG_DIV_LO      4
`define PCD_CFG_DIV_HI      7

// status field positions
`define PCD_STS_PIN_BIT     0
`define PCD_STS_RUN_BIT     1
`define PCD_STS_CNT_LO      8
`define PCD_STS_CNT_HI      15

// reset values
`define PCD_RST_CONFIG      8'h00
`define PCD_RST_DUTY        8'h00
`define PCD_RST_WORD        32'h0000_0000

// fixed frame length of the duty stage
`define PCD_FRAME_PERIODS   256

`endif

// ### pcd_pkg.sv
package pcd_pkg;

  // source clock choice
  typedef enum logic [1:0] {
    SRC_PRIMARY   = 2'b00,
    SRC_SECONDARY = 2'b01,
    SRC_BUS       = 2'b10,
    SRC_FOURTH    = 2'b11
  } pcd_src_t;

  // bus answer state, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } pcd_bus_t;

endpackage : pcd_pkg

// ### pcd_prescaler.sv
`timescale 1ns/100ps
`default_nettype none

module pcd_prescaler #(
  parameter int CNT_W = 15
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // control
  input  wire logic             run,
  input  wire logic [3:0]       div_sel,
  input  wire logic             src_edge,
  // divided clock as one-cycle pulse
  output logic                  tick
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] limit;

  // last count of a 2**div_sel span
  function automatic logic [CNT_W-1:0] span_last(input logic [3:0] sel);
    logic [CNT_W:0] one;
    one       = '0;
    one[0]    = 1'b1;
    span_last = CNT_W'((one << sel) - 1'b1);
  endfunction : span_last

  assign limit = span_last(div_sel);
  // >= so that a smaller divider chosen mid-span does not wait a full wrap
  assign tick  = run & src_edge & (cnt >= limit);

  // count source edges; held clear while stopped
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      cnt <= '0;
    end else if (src_edge) begin
      cnt <= tick ? '0 : cnt + 1'b1;
    end
  end

endmodule : pcd_prescaler

`default_nettype wire

// ### pcd_duty_gen.sv
`timescale 1ns/100ps
`default_nettype none

module pcd_duty_gen #(
  parameter int DUTY_W = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // control
  input  wire logic              run,
  input  wire logic              tick,
  input  wire logic [DUTY_W-1:0] duty,
  // frame position and wanted level
  output logic      [DUTY_W-1:0] count,
  output logic                   high
);

  // free-running frame counter, one step per divided period
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      count <= '0;
    end else if (tick) begin
      count <= count + 1'b1;
    end
  end

  // duty 0 never compares true, so the output stays low
  assign high = run & (count < duty);

endmodule : pcd_duty_gen

`default_nettype wire

// ### pcd_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "pcd_defines.svh"

// How it works
// - The selected source is divided by two to the power of the 4-bit divide field, 1 to 32768.
// - The divided clock is further divided by 256 before it reaches the output pin.
// - With the force-high bit set the output pin is held high whatever the duty.
// - With the force-high bit clear the enable bit decides how the pin behaves.
// - A 2-bit select picks primary, secondary, bus or fourth clock as the source.
// - With enable clear the pin is a plain output that follows the force-high bit.
// - With enable set and power save off the divider and duty stages run and make the waveform.
// - Power-save mode stops the divider and duty stages whatever the enable bit says.
// - The pin is high for N of every 256 divided periods, N being the duty value.
// - The duty register uses bits 7 to 0, upper bits read zero, and it resets to zero.
module pcd_top #(
  parameter int DIV_CNT_W = 15,
  parameter int DUTY_W    = 8
) (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  // avalon-mm slave
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // candidate source clocks, sampled as levels
  input  wire logic        PRIMARY_INPUT_CLOCK,
  input  wire logic        SECONDARY_INPUT_CLOCK,
  input  wire logic        BUS_CLOCK,
  input  wire logic        FOURTH_CLOCK,
  // power management
  input  wire logic        POWER_SAVE,
  // pwm pin
  output logic             PWM_OUTPUT_PIN
);

  pcd_pkg::pcd_bus_t      bus_state;
  pcd_pkg::pcd_bus_t      next_bus_state;
  pcd_pkg::pcd_src_t      src_sel;
  logic [7:0]             cfg;
  logic [DUTY_W-1:0]      duty;
  logic [3:0]             src_now;
  logic [3:0]             src_prev;
  logic [3:0]             src_rise;
  logic                   pwm_source_clock;
  logic                   run;
  logic                   tick;
  logic [DUTY_W-1:0]      count;
  logic                   high;
  logic                   req;
  logic                   wr_ok;
  logic                   next_pin;
  logic [31:0]            next_rdata;
  logic                   edge_ticked;

  // word address compare, shared by read and write decode
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr[7:2] == ofs[7:2]);
  endfunction : hit

  // ---------------- bus slave ----------------

  assign req             = AVS_READ | AVS_WRITE;
  // one wait cycle for every access, so readdata always comes from a flop
  assign AVS_WAITREQUEST = req & (bus_state == pcd_pkg::BUS_IDLE);
  assign wr_ok           = AVS_WRITE & (bus_state == pcd_pkg::BUS_ACK);

  // answer state
  always_comb begin
    next_bus_state = pcd_pkg::BUS_IDLE;
    unique case (bus_state)
      pcd_pkg::BUS_IDLE: begin
        next_bus_state = req ? pcd_pkg::BUS_ACK : pcd_pkg::BUS_IDLE;
      end
      pcd_pkg::BUS_ACK: begin
        next_bus_state = pcd_pkg::BUS_IDLE;
      end
      default: begin
        next_bus_state = pcd_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      bus_state <= pcd_pkg::BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // configuration register, low byte only
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      cfg <= `PCD_RST_CONFIG;
    end else if (wr_ok && hit(AVS_ADDRESS, `PCD_OFS_CONFIG) && AVS_BYTEENABLE[0]) begin
      cfg <= AVS_WRITEDATA[7:0];
    end
  end

  // duty register, bits 7..0 kept, upper bits dropped
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      duty <= `PCD_RST_DUTY;
    end else if (wr_ok && hit(AVS_ADDRESS, `PCD_OFS_DUTY) && AVS_BYTEENABLE[0]) begin
      duty <= AVS_WRITEDATA[DUTY_W-1:0];
    end
  end

  // read mux; unmapped words answer zero
  always_comb begin
    next_rdata = `PCD_RST_WORD;
    if (hit(AVS_ADDRESS, `PCD_OFS_CONFIG)) begin
      next_rdata[7:0] = cfg;
    end else if (hit(AVS_ADDRESS, `PCD_OFS_DUTY)) begin
      next_rdata[DUTY_W-1:0] = duty;
    end else if (hit(AVS_ADDRESS, `PCD_OFS_STATUS)) begin
      next_rdata[`PCD_STS_PIN_BIT]                   = PWM_OUTPUT_PIN;
      next_rdata[`PCD_STS_RUN_BIT]                   = run;
      next_rdata[`PCD_STS_CNT_HI:`PCD_STS_CNT_LO]    = count;
    end
  end

  // capture read data in the wait cycle so it stands when waitrequest drops
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      AVS_READDATA <= `PCD_RST_WORD;
    end else if (AVS_READ && bus_state == pcd_pkg::BUS_IDLE) begin
      AVS_READDATA <= next_rdata;
    end
  end

  // ---------------- source clock selection ----------------

  assign src_now = {FOURTH_CLOCK, BUS_CLOCK, SECONDARY_INPUT_CLOCK, PRIMARY_INPUT_CLOCK};
  assign src_sel = pcd_pkg::pcd_src_t'(cfg[`PCD_CFG_SRC_HI:`PCD_CFG_SRC_LO]);

  // rising edge of each candidate; sources must run no faster than half of SYS_CLK
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_edge
      always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
          src_prev[gi] <= 1'b0;
        end else begin
          src_prev[gi] <= src_now[gi];
        end
      end
      assign src_rise[gi] = src_now[gi] & ~src_prev[gi];
    end
  endgenerate

  // edges are prepared for all four so switching source never sees a stale history
  assign pwm_source_clock = src_rise[src_sel];

  // ---------------- divider and duty ----------------

  assign run = cfg[`PCD_CFG_ENABLE_BIT] & ~POWER_SAVE;

  pcd_prescaler #(
    .CNT_W    (DIV_CNT_W)
  ) u_prescaler (
    .clk      (SYS_CLK),
    .rst_n    (RST_N),
    .run      (run),
    .div_sel  (cfg[`PCD_CFG_DIV_HI:`PCD_CFG_DIV_LO]),
    .src_edge (pwm_source_clock),
    .tick     (tick)
  );

  pcd_duty_gen #(
    .DUTY_W (DUTY_W)
  ) u_duty (
    .clk    (SYS_CLK),
    .rst_n  (RST_N),
    .run    (run),
    .tick   (tick),
    .duty   (duty),
    .count  (count),
    .high   (high)
  );

  // pin level: force wins, then enable picks waveform or plain output
  always_comb begin
    if (cfg[`PCD_CFG_FORCE_BIT]) begin
      next_pin = 1'b1;
    end else if (cfg[`PCD_CFG_ENABLE_BIT]) begin
      next_pin = high;
    end else begin
      next_pin = cfg[`PCD_CFG_FORCE_BIT];
    end
  end

  // registered pin avoids glitches from the compare
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      PWM_OUTPUT_PIN <= 1'b0;
    end else begin
      PWM_OUTPUT_PIN <= next_pin;
    end
  end

  // ---------------- checks ----------------

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  sequence seq_req_start;
    req && bus_state == pcd_pkg::BUS_IDLE;
  endsequence

  sequence seq_duty_read;
    AVS_READ && hit(AVS_ADDRESS, `PCD_OFS_DUTY) && bus_state == pcd_pkg::BUS_IDLE;
  endsequence

  sequence seq_answer;
    !AVS_WAITREQUEST && bus_state == pcd_pkg::BUS_ACK;
  endsequence

  AST_FORCE_HIGH: assert property (
    cfg[`PCD_CFG_FORCE_BIT] |=> PWM_OUTPUT_PIN)
    else $error("force-high set but pin low");

  AST_GPO_LOW: assert property (
    !cfg[`PCD_CFG_ENABLE_BIT] && !cfg[`PCD_CFG_FORCE_BIT] |=> !PWM_OUTPUT_PIN)
    else $error("disabled output not following force bit");

  AST_ENABLE_DECIDES: assert property (
    !cfg[`PCD_CFG_FORCE_BIT] && cfg[`PCD_CFG_ENABLE_BIT] |=> PWM_OUTPUT_PIN == $past(high))
    else $error("enabled pin not showing duty level");

  AST_PSAVE_STOP: assert property (
    POWER_SAVE |-> !tick ##1 (count == '0))
    else $error("divider running in power save");

  AST_IDLE_NO_TICK: assert property (
    !cfg[`PCD_CFG_ENABLE_BIT] |-> !tick)
    else $error("divided clock ticks while disabled");

  AST_DIV1_TICK: assert property (
    run && cfg[`PCD_CFG_DIV_HI:`PCD_CFG_DIV_LO] == 4'h0 && pwm_source_clock |-> tick)
    else $error("divide by one missed a source edge");

  // remembers whether the previous selected edge while running gave a tick;
  // source edges are at least two cycles apart, so the check keys on edges, not cycles
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || !run) begin
      edge_ticked <= 1'b0;
    end else if (pwm_source_clock) begin
      edge_ticked <= tick;
    end
  end

  sequence seq_div2_edge;
    run && cfg[`PCD_CFG_DIV_HI:`PCD_CFG_DIV_LO] == 4'h1 && pwm_source_clock;
  endsequence

  AST_DIV2_SKIP: assert property (
    seq_div2_edge ##0 edge_ticked |-> !tick)
    else $error("divide by two ticked on adjacent source edges");

  AST_SRC_SEL: assert property (
    src_sel == pcd_pkg::SRC_BUS |-> pwm_source_clock == (BUS_CLOCK && !src_prev[2]))
    else $error("bus clock not routed when selected");

  AST_FRAME_STEP: assert property (
    tick |=> count == DUTY_W'($past(count) + 1'b1))
    else $error("frame counter did not advance on divided tick");

  AST_DUTY_ZERO: assert property (
    duty == '0 && !cfg[`PCD_CFG_FORCE_BIT] |=> !PWM_OUTPUT_PIN)
    else $error("duty zero but pin high");

  AST_DUTY_FULL: assert property (
    run && !cfg[`PCD_CFG_FORCE_BIT] && duty == 8'hFF && count != 8'hFF |=> PWM_OUTPUT_PIN)
    else $error("duty full but pin low below top count");

  AST_DUTY_UPPER_ZERO: assert property (
    seq_duty_read |=> seq_answer ##0 (AVS_READDATA[31:DUTY_W] == '0))
    else $error("duty register upper bits not zero");

  AST_ONE_WAIT: assert property (
    seq_req_start |-> AVS_WAITREQUEST ##1 seq_answer)
    else $error("bus answer not after exactly one wait cycle");

  AST_DUTY_LOW_SPAN: assert property (
    run && !cfg[`PCD_CFG_FORCE_BIT] && count >= duty |=> !PWM_OUTPUT_PIN)
    else $error("pin high at or above the duty count");

  AST_STOPPED_CLEAR: assert property (
    !run |=> count == '0)
    else $error("frame counter not cleared while stopped");

  AST_DUTY_WRITE: assert property (
    wr_ok && hit(AVS_ADDRESS, `PCD_OFS_DUTY) && AVS_BYTEENABLE[0]
      |=> duty == $past(AVS_WRITEDATA[DUTY_W-1:0]))
    else $error("duty write did not land in bits 7 to 0");

endmodule : pcd_top

`default_nettype wire

// ### test_pwm_clock_duty_output.sv
`timescale 1ns/100ps
`default_nettype none
`include "pcd_defines.svh"

module test_pwm_clock_duty_output;
  // bus, source and pin signals
  logic        sys_clk   = 1'b0;
  logic        rst_n     = 1'b0;
  logic [7:0]  addr      = 8'h00;
  logic        rd        = 1'b0;
  logic        wr        = 1'b0;
  logic [3:0]  be        = 4'hF;
  logic [31:0] wdata     = 32'h0000_0000;
  logic [31:0] rdata;
  logic        wait_req;
  logic [3:0]  src_clk   = 4'h0;
  logic        pwr_save  = 1'b0;
  logic        pin;
  // bookkeeping
  int          hi_cnt    = 0;
  int          base;
  int          error_cnt = 0;
  int          num_checks = 0;
  // frame table: source, divide code, duty
  int          f_src [5] = '{0, 0, 1, 2, 3};
  int          f_div [5] = '{0, 1, 0, 2, 0};
  logic [7:0]  f_duty[5] = '{8'h00, 8'h40, 8'hFF, 8'h81, 8'h01};

  // 25 MHz system clock
  always #20 sys_clk = ~sys_clk;

  pcd_top u_pcd_top (
    .SYS_CLK              (sys_clk),
    .RST_N                (rst_n),
    .AVS_ADDRESS          (addr),
    .AVS_READ             (rd),
    .AVS_WRITE            (wr),
    .AVS_BYTEENABLE       (be),
    .AVS_WRITEDATA        (wdata),
    .AVS_READDATA         (rdata),
    .AVS_WAITREQUEST      (wait_req),
    .PRIMARY_INPUT_CLOCK  (src_clk[0]),
    .SECONDARY_INPUT_CLOCK(src_clk[1]),
    .BUS_CLOCK            (src_clk[2]),
    .FOURTH_CLOCK         (src_clk[3]),
    .POWER_SAVE           (pwr_save),
    .PWM_OUTPUT_PIN       (pin)
  );

  // running total of cycles with the pin high; windows take differences
  always @(posedge sys_clk) begin
    if (pin === 1'b1) begin
      hi_cnt <= hi_cnt + 1;
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic results();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // one access; an idle edge follows so back-to-back calls never re-drive in one step
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    int n;
    n = 0;
    addr  <= a;
    wdata <= d;
    be    <= b;
    wr    <= w;
    rd    <= ~w;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wait_req !== 1'b0);
    check("wait cycles", 32'(n), 32'h0000_0002);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask : wr32

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hF, q);
    check(name, q, exp);
  endtask : rd_chk

  // n rising edges on one source, one system cycle per level
  task automatic gen(input int s, input int n);
    repeat (n) begin
      src_clk[s] <= 1'b1;
      @(posedge sys_clk);
      src_clk[s] <= 1'b0;
      @(posedge sys_clk);
    end
  endtask : gen

  // pin is registered, so let its cause land before looking
  task automatic pin_chk(input string name, input logic exp);
    repeat (2) @(posedge sys_clk);
    check(name, {31'h0000_0000, pin}, {31'h0000_0000, exp});
  endtask : pin_chk

  // hang guard, sized above the roughly 76k cycles the tests need
  initial begin
    repeat (95000) @(posedge sys_clk);
    error_cnt++;
    results();
  end

  initial begin
    logic [31:0] q;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset values and register fields
    rd_chk("config reset", `PCD_OFS_CONFIG, 32'h0000_0000);
    rd_chk("duty reset", `PCD_OFS_DUTY, 32'h0000_0000);
    check("pin reset", {31'h0000_0000, pin}, 32'h0000_0000);
    wr32(`PCD_OFS_DUTY, 32'hFFFF_FF5A);
    rd_chk("duty width", `PCD_OFS_DUTY, 32'h0000_005A);
    bus(1'b1, `PCD_OFS_DUTY, 32'h0000_0011, 4'h0, q);
    rd_chk("duty lane off", `PCD_OFS_DUTY, 32'h0000_005A);
    rd_chk("unmapped", 8'h7C, 32'h0000_0000);
    // force and general-purpose behaviour
    wr32(`PCD_OFS_CONFIG, 32'hFFFF_FF08);
    rd_chk("config width", `PCD_OFS_CONFIG, 32'h0000_0008);
    pin_chk("forced pin", 1'b1);
    wr32(`PCD_OFS_CONFIG, 32'h0000_0000);
    pin_chk("plain pin low", 1'b0);
    wr32(`PCD_OFS_DUTY, 32'h0000_0000);
    wr32(`PCD_OFS_CONFIG, 32'h0000_0001);
    gen(0, 20);
    pin_chk("enabled duty zero", 1'b0);
    // one settling frame, then one measured frame per table row
    for (int i = 0; i < 5; i++) begin
      wr32(`PCD_OFS_CONFIG, 32'h0000_0000);
      wr32(`PCD_OFS_DUTY, {24'h00_0000, f_duty[i]});
      wr32(`PCD_OFS_CONFIG, 32'(1 + f_src[i] * 2 + f_div[i] * 16));
      gen(f_src[i], 256 << f_div[i]);
      base = hi_cnt;
      gen(f_src[i], 256 << f_div[i]);
      check("high time", 32'(hi_cnt - base), 32'(f_duty[i] * 2 * (1 << f_div[i])));
    end
    // power save stops the stages whatever enable says
    wr32(`PCD_OFS_CONFIG, 32'h0000_0000);
    wr32(`PCD_OFS_DUTY, 32'h0000_0080);
    wr32(`PCD_OFS_CONFIG, 32'h0000_0001);
    gen(0, 10);
    pin_chk("running pin", 1'b1);
    rd_chk("status running", `PCD_OFS_STATUS, 32'h0000_0A03);
    pwr_save <= 1'b1;
    pin_chk("power save pin", 1'b0);
    rd_chk("status power save", `PCD_OFS_STATUS, 32'h0000_0000);
    base = hi_cnt;
    gen(0, 300);
    check("power save high", 32'(hi_cnt - base), 32'h0000_0000);
    wr32(`PCD_OFS_CONFIG, 32'h0000_0009);
    pin_chk("power save forced", 1'b1);
    pwr_save <= 1'b0;
    // largest divide code: one tick needs 32768 source edges
    wr32(`PCD_OFS_CONFIG, 32'h0000_0000);
    wr32(`PCD_OFS_DUTY, 32'h0000_0001);
    wr32(`PCD_OFS_CONFIG, 32'h0000_00F1);
    gen(0, 32767);
    pin_chk("before top tick", 1'b1);
    gen(0, 1);
    pin_chk("after top tick", 1'b0);
    results();
  end
endmodule : test_pwm_clock_duty_output

`default_nettype wire
